/* scrx_baud.sv */
// Prescaler and power-of-two divider giving the sample slot tick
`timescale 1ns/1ps
module scrx_baud (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] prescaleSelect,
  input  wire logic [2:0] divisorSelect,
  output logic            sampleTick
);
  logic [3:0]  preCnt, next_preCnt, preMax;
  logic [6:0]  divCnt, next_divCnt, divMax;
  logic        next_sampleTick;

  // Divisor decode and counters
  always_comb begin
    case (prescaleSelect)
      2'h0:    preMax = 4'h0;
      2'h1:    preMax = 4'h2;
      2'h2:    preMax = 4'h3;
      default: preMax = 4'hC;
    endcase
    divMax = 7'((8'h01 << divisorSelect) - 8'h01);
    next_preCnt     = preCnt;
    next_divCnt     = divCnt;
    next_sampleTick = 1'b0;
    if (preCnt >= preMax) begin
      next_preCnt = 4'h0;
      if (divCnt >= divMax) begin
        next_divCnt     = 7'h00;
        next_sampleTick = 1'b1;
      end else begin
        next_divCnt = divCnt + 7'h01;
      end
    end else begin
      next_preCnt = preCnt + 4'h1;
    end
  end

  // Counter registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      preCnt     <= 4'h0;
      divCnt     <= 7'h00;
      sampleTick <= 1'b0;
    end else begin
      preCnt     <= next_preCnt;
      divCnt     <= next_divCnt;
      sampleTick <= next_sampleTick;
    end
  end
endmodule : scrx_baud

/* scrx_checker.sv */
// Port assertions for the serial receiver top
`include "scrx_defs.svh"
`timescale 1ns/1ps
module scrx_checker
  import scrx_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        errorIrq,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  logic enWritten;
  logic next_enWritten;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Enable register addressed since reset
  always_comb begin
    next_enWritten = enWritten;
    if (s_axi_awvalid && s_axi_awready &&
        s_axi_awaddr == `SCRX_OFF_CONTROL3)
      next_enWritten = 1'b1;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n)
      enWritten <= 1'b0;
    else
      enWritten <= next_enWritten;
  end
  // Channel handshakes
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_reset_quiet: assert property ($rose(rst_n) |->
    !errorIrq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  a_irq_needs_enable: assert property (!enWritten |-> !errorIrq)
    else $error("error request with enables cleared");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer not held");
  a_rd_single: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("write not answered");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer not held");
  a_rd_unmapped: assert property (s_rd_taken ##0
    s_axi_araddr > 8'h14 |=> s_axi_rresp == RESP_SLVERR &&
    s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : scrx_checker

bind scrx_top scrx_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .errorIrq(errorIrq),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready)
);

/* scrx_defs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SCRX_DEFS_SVH
`define SCRX_DEFS_SVH
`define SCRX_OFF_STATUS1    8'h00
`define SCRX_OFF_STATUS2    8'h04
`define SCRX_OFF_CONTROL1   8'h08
`define SCRX_OFF_CONTROL3   8'h0C
`define SCRX_OFF_DATA       8'h10
`define SCRX_OFF_CLEAR      8'h14
`define SCRX_S1_FULL        5
`define SCRX_S1_OVERRUN     3
`define SCRX_S1_NOISE       2
`define SCRX_S1_FRAMING     1
`define SCRX_S1_PARITY      0
`define SCRX_S2_BREAK       1
`define SCRX_S2_ACTIVE      0
`define SCRX_C3_NINTH       7
`define SCRX_C3_OVERRUN_IE  3
`define SCRX_C3_NOISE_IE    2
`define SCRX_C3_FRAMING_IE  1
`define SCRX_C3_PARITY_IE   0
`define SCRX_C1_NINE_BIT    4
`define SCRX_C1_PAR_EN      3
`define SCRX_C1_PAR_ODD     2
`define SCRX_C1_ENABLE      1
`define SCRX_C1_RESET       8'h00
`define SCRX_C3_RESET       8'h00
`define SCRX_SPEED_RESET    8'h00
`define SCRX_SLOTS          16
`define SCRX_FIFO_DEPTH     8
`endif

/* scrx_fifo.sv */
// Received character FIFO with valid and ready on both sides
`timescale 1ns/1ps
module scrx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr, next_wrPtr, rdPtr, next_rdPtr;
  logic [AW:0]      count, next_count;
  logic             doWr, doRd;

  // Handshakes and pointer updates
  always_comb begin
    inReady    = (count != DEPTH[AW:0]);
    outValid   = (count != '0);
    outData    = mem[rdPtr];
    doWr       = inValid && inReady;
    doRd       = outValid && outReady;
    next_wrPtr = doWr ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = doRd ? rdPtr + 1'b1 : rdPtr;
    next_count = count + {{AW{1'b0}}, doWr} - {{AW{1'b0}}, doRd};
  end

  // Pointer registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
  end

  // Storage
  always_ff @(posedge ref_clk) begin
    if (doWr) begin
      mem[wrPtr] <= inData;
    end
  end
endmodule : scrx_fifo

/* scrx_pkg.sv */
// Types shared by the serial receiver files
package scrx_pkg;
  typedef struct packed {
    logic       ninth;
    logic [7:0] data;
    logic       framing;
    logic       noise;
    logic       parity;
    logic       brk;
  } scrx_char_t;
  typedef enum logic [1:0] {RESP_OKAY = 2'b00, RESP_SLVERR = 2'b10}
    scrx_resp_t;
endpackage : scrx_pkg

/* scrx_top.sv */
// Serial receiver with error flags, break detection and AXI4-Lite registers
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`include "scrx_defs.svh"
`timescale 1ns/1ps
module scrx_top
  import scrx_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        rxLine,
  output logic             errorIrq,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef enum {ST_IDLE, ST_START, ST_DATA, ST_STOP} scrx_state_t;

  // Line synchroniser and sample tick
  logic       rxMeta, rxSync, sampleTick;
  logic [7:0] control1, control3, speed;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rxMeta <= 1'b1;
      rxSync <= 1'b1;
    end else begin
      rxMeta <= rxLine;
      rxSync <= rxMeta;
    end
  end

  scrx_baud u_baud (
    .ref_clk        (ref_clk),
    .rst_n          (rst_n),
    .prescaleSelect (speed[5:4]),
    .divisorSelect  (speed[2:0]),
    .sampleTick     (sampleTick)
  );

  // Receiver state
  scrx_state_t state, next_state;
  logic [3:0]  slot, next_slot, bitIdx, next_bitIdx;
  logic [8:0]  shift, next_shift;
  logic [2:0]  votes, next_votes;
  logic        noiseSeen, next_noiseSeen;
  logic        rxActive, next_rxActive;
  logic        breakArmed, next_breakArmed;
  logic [3:0]  idleCnt, next_idleCnt;
  logic        charValid;
  scrx_char_t  charOut, fifoOut;
  logic        fifoInReady, fifoOutValid, fifoPop;
  logic [3:0]  nBits;
  logic        sampled, majority, parOk, isBreak;

  // Character framing, voting and break detection
  always_comb begin
    next_state      = state;
    next_slot       = slot;
    next_bitIdx     = bitIdx;
    next_shift      = shift;
    next_votes      = votes;
    next_noiseSeen  = noiseSeen;
    next_rxActive   = rxActive;
    next_breakArmed = breakArmed;
    next_idleCnt    = idleCnt;
    charValid       = 1'b0;
    charOut         = '0;
    nBits = control1[`SCRX_C1_NINE_BIT] ? 4'd9 : 4'd8;
    sampled = rxSync;
    majority = (votes[0] & votes[1]) | (votes[1] & sampled) |
               (votes[0] & sampled);
    parOk   = ^{shift, control1[`SCRX_C1_PAR_ODD]} == 1'b0;
    isBreak = (shift == 9'h000) && !majority;
    if (rxSync) begin
      next_breakArmed = 1'b1;
    end
    if (sampleTick && control1[`SCRX_C1_ENABLE]) begin
      next_slot = slot + 4'h1;
      if (slot >= 4'd7 && slot <= 4'd9) begin
        next_votes = {votes[1:0], sampled};
      end
      case (state)
        ST_IDLE: begin
          next_slot = 4'h0;
          if (!sampled) begin
            next_state    = ST_START;
            next_slot     = 4'h1;
            next_rxActive = 1'b1;
            next_idleCnt  = 4'h0;
          end else if (rxActive || idleCnt != 4'hF) begin
            next_idleCnt = idleCnt + 4'h1;
            if (idleCnt == 4'hF) begin
              next_rxActive = 1'b0;
            end
          end
        end
        ST_START: begin
          if (slot == 4'd9 && majority) begin
            next_state    = ST_IDLE;
            next_rxActive = 1'b0;
            next_idleCnt  = 4'h0;
          end else if (slot == 4'hF) begin
            next_state     = ST_DATA;
            next_bitIdx    = 4'h0;
            next_noiseSeen = (votes != 3'b000);
          end
        end
        ST_DATA: begin
          if (slot == 4'hF) begin
            next_shift  = {majority, shift[8:1]};
            next_bitIdx = bitIdx + 4'h1;
            if (votes != 3'b000 && votes != 3'b111) begin
              next_noiseSeen = 1'b1;
            end
            if (bitIdx == nBits - 4'h1) begin
              next_state = ST_STOP;
              if (nBits == 4'd8) begin
                next_shift = {1'b0, majority, shift[8:2]};
              end
            end
          end
        end
        default: begin
          if (slot == 4'd9) begin
            next_state   = ST_IDLE;
            next_idleCnt = 4'h0;
            charValid    = !isBreak || breakArmed;
            charOut.brk  = isBreak;
            charOut.framing = !majority;
            charOut.noise   = noiseSeen;
            charOut.parity  = control1[`SCRX_C1_PAR_EN] &&
                              !isBreak && !parOk;
            charOut.data  = shift[7:0];
            charOut.ninth = isBreak ? 1'b0 : shift[8];
            if (isBreak) begin
              next_breakArmed = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Receiver registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state      <= ST_IDLE;
      slot       <= 4'h0;
      bitIdx     <= 4'h0;
      shift      <= 9'h000;
      votes      <= 3'b111;
      noiseSeen  <= 1'b0;
      rxActive   <= 1'b0;
      breakArmed <= 1'b1;
      idleCnt    <= 4'h0;
    end else begin
      state      <= next_state;
      slot       <= next_slot;
      bitIdx     <= next_bitIdx;
      shift      <= next_shift;
      votes      <= next_votes;
      noiseSeen  <= next_noiseSeen;
      rxActive   <= next_rxActive;
      breakArmed <= next_breakArmed;
      idleCnt    <= next_idleCnt;
    end
  end

  scrx_fifo #(.WIDTH($bits(scrx_char_t)), .DEPTH(`SCRX_FIFO_DEPTH)) u_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .inData   (charOut),
    .inValid  (charValid),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (fifoPop)
  );

  // Register bus and flags
  logic       wrAddrHeld, next_wrAddrHeld, wrDataHeld, next_wrDataHeld;
  logic [7:0] wrAddr, next_wrAddr;
  logic [31:0] wrData, next_wrData;
  logic [7:0] next_control1, next_control3, next_speed;
  logic       overrun, next_overrun, breakFlag, next_breakFlag;
  logic       breakSeen, next_breakSeen;
  logic [31:0] rdValue, next_rdata;
  logic       next_bvalid, next_rvalid, next_bErr, next_rErr, bErr, rErr;
  logic       doWrite, doRead;
  logic [7:0] status1, status2;

  always_comb begin
    status1 = 8'h00;
    status1[`SCRX_S1_FULL]    = fifoOutValid;
    status1[`SCRX_S1_OVERRUN] = overrun;
    status1[`SCRX_S1_NOISE]   = fifoOutValid && fifoOut.noise;
    status1[`SCRX_S1_FRAMING] = fifoOutValid && fifoOut.framing;
    status1[`SCRX_S1_PARITY]  = fifoOutValid && fifoOut.parity;
    status2 = {6'h00, breakFlag, rxActive};
    // Error request; break and active flags are left out on purpose
    errorIrq = (overrun && control3[`SCRX_C3_OVERRUN_IE]) ||
      (status1[`SCRX_S1_NOISE] && control3[`SCRX_C3_NOISE_IE]) ||
      (status1[`SCRX_S1_FRAMING] && control3[`SCRX_C3_FRAMING_IE]) ||
      (status1[`SCRX_S1_PARITY] && control3[`SCRX_C3_PARITY_IE]);
    s_axi_awready = !wrAddrHeld && !s_axi_bvalid;
    s_axi_wready  = !wrDataHeld && !s_axi_bvalid;
    s_axi_arready = !s_axi_rvalid;
    next_wrAddrHeld = wrAddrHeld || (s_axi_awvalid && s_axi_awready);
    next_wrDataHeld = wrDataHeld || (s_axi_wvalid && s_axi_wready);
    next_wrAddr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wrAddr;
    next_wrData = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wrData;
    doWrite = next_wrAddrHeld && next_wrDataHeld && !s_axi_bvalid;
    doRead  = s_axi_arvalid && s_axi_arready;
    next_control1 = control1;
    next_control3 = control3;
    next_speed    = speed;
    next_bErr     = bErr;
    next_bvalid   = s_axi_bvalid && !s_axi_bready;
    if (doWrite) begin
      next_wrAddrHeld = 1'b0;
      next_wrDataHeld = 1'b0;
      next_bvalid     = 1'b1;
      next_bErr       = 1'b0;
      case (next_wrAddr)
        // Whole low byte is stored; ninth bit stays read-only
        `SCRX_OFF_CONTROL1: next_control1 = next_wrData[7:0];
        `SCRX_OFF_CONTROL3: next_control3 = {control3[7], next_wrData[6:0]};
        `SCRX_OFF_CLEAR:    next_speed    = next_wrData[7:0];
        `SCRX_OFF_STATUS1, `SCRX_OFF_STATUS2, `SCRX_OFF_DATA: ;
        default: next_bErr = 1'b1;
      endcase
    end
    // Ninth bit tracks the character at the head of the FIFO
    next_control3[`SCRX_C3_NINTH] = fifoOutValid && fifoOut.ninth;
    rdValue = 32'h0000_0000;
    next_rErr = 1'b0;
    case (s_axi_araddr)
      `SCRX_OFF_STATUS1:  rdValue[7:0] = status1;
      `SCRX_OFF_STATUS2:  rdValue[7:0] = status2;
      `SCRX_OFF_CONTROL1: rdValue[7:0] = control1;
      `SCRX_OFF_CONTROL3: rdValue[7:0] = control3;
      `SCRX_OFF_DATA:     rdValue[7:0] = fifoOut.data;
      `SCRX_OFF_CLEAR:    rdValue[7:0] = speed;
      default:            next_rErr = 1'b1;
    endcase
    next_rdata  = doRead ? rdValue : s_axi_rdata;
    next_rvalid = doRead || (s_axi_rvalid && !s_axi_rready);
    next_rErr   = doRead ? next_rErr : rErr;
    fifoPop = doRead && s_axi_araddr == `SCRX_OFF_DATA && fifoOutValid;
    // Break clear needs a status-two read with it set, then a data read
    next_breakSeen = breakSeen;
    next_breakFlag = breakFlag;
    if (doRead && s_axi_araddr == `SCRX_OFF_STATUS2 && breakFlag) begin
      next_breakSeen = 1'b1;
    end
    if (doRead && s_axi_araddr == `SCRX_OFF_DATA && breakSeen) begin
      next_breakFlag = 1'b0;
      next_breakSeen = 1'b0;
    end
    if (charValid && charOut.brk) begin
      next_breakFlag = 1'b1;
    end
    // Overrun set wins over the data-read clear
    next_overrun = overrun;
    if (fifoPop) begin
      next_overrun = 1'b0;
    end
    if (charValid && !fifoInReady) begin
      next_overrun = 1'b1;
    end
    s_axi_bresp = bErr ? RESP_SLVERR : RESP_OKAY;
    s_axi_rresp = rErr ? RESP_SLVERR : RESP_OKAY;
  end

  // Register bus registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      control1     <= `SCRX_C1_RESET;
      control3     <= `SCRX_C3_RESET;
      speed        <= `SCRX_SPEED_RESET;
      overrun      <= 1'b0;
      breakFlag    <= 1'b0;
      breakSeen    <= 1'b0;
      wrAddrHeld   <= 1'b0;
      wrDataHeld   <= 1'b0;
      wrAddr       <= 8'h00;
      wrData       <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      bErr         <= 1'b0;
      rErr         <= 1'b0;
    end else begin
      control1     <= next_control1;
      control3     <= next_control3;
      speed        <= next_speed;
      overrun      <= next_overrun;
      breakFlag    <= next_breakFlag;
      breakSeen    <= next_breakSeen;
      wrAddrHeld   <= next_wrAddrHeld;
      wrDataHeld   <= next_wrDataHeld;
      wrAddr       <= next_wrAddr;
      wrData       <= next_wrData;
      s_axi_bvalid <= next_bvalid;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      bErr         <= next_bErr;
      rErr         <= next_rErr;
    end
  end
endmodule : scrx_top

/* scrx_tx_model.sv */
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
module scrx_tx_model (
  input wire logic ref_clk,
  output logic     rxLine
);
  // Line rests high between frames
  initial rxLine = 1'b1;
  // Start, data LSB first, stop level, each held bitClk cycles
  task automatic send(input logic [8:0] bits, input int nBits,
                      input logic stopLvl, input int bitClk);
    for (int i = 0; i < nBits + 2; i++) begin
      if (i == 0)
        rxLine <= 1'b0;
      else if (i <= nBits)
        rxLine <= bits[i - 1];
      else
        rxLine <= stopLvl;
      repeat (bitClk) @(posedge ref_clk);
    end
    rxLine <= 1'b1;
    repeat (bitClk) @(posedge ref_clk);
  endtask : send
  // Low pulse held n cycles; a short one only looks like a start edge
  task automatic glitch(input int n);
    rxLine <= 1'b0;
    repeat (n) @(posedge ref_clk);
    rxLine <= 1'b1;
  endtask : glitch
endmodule : scrx_tx_model

/* tb_serial_rx_error_and_baud_select.sv */
// Self-checking bench for the serial receiver block
`include "scrx_defs.svh"
`timescale 1ns/1ps
module tb_serial_rx_error_and_baud_select
  import scrx_pkg::*;
;
  localparam logic [7:0] S1 = `SCRX_OFF_STATUS1;
  localparam logic [7:0] S2 = `SCRX_OFF_STATUS2;
  localparam logic [7:0] C1 = `SCRX_OFF_CONTROL1;
  localparam logic [7:0] C3 = `SCRX_OFF_CONTROL3;
  localparam logic [7:0] DT = `SCRX_OFF_DATA;
  localparam logic [7:0] SP = `SCRX_OFF_CLEAR;
  logic        ref_clk;
  logic        rst_n;
  logic        rxLine;
  logic        errorIrq;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  int          mismatches;
  int          checked;
  int          bitClk;
  bit          slowAck;
  logic [15:0] lfsr;
  logic [31:0] rd;
  logic [1:0]  lastResp;
  logic [7:0]  ch;
  logic [7:0]  sent [9];

  scrx_top u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .rxLine(rxLine),
    .errorIrq(errorIrq), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
  );
  scrx_tx_model u_tx (.ref_clk(ref_clk), .rxLine(rxLine));

  // Clock and watchdog
  always #10 ref_clk = ~ref_clk;
  initial begin
    repeat (60000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end

  function automatic logic [7:0] next_char();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction : next_char

  function automatic int bit_clocks(input logic [1:0] ps,
                                    input logic [2:0] ds);
    int pd [4] = '{1, 3, 4, 13};
    return 16 * pd[ps] * (1 << ds);
  endfunction : bit_clocks

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= !slowAck;
    do begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready)
        s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= !slowAck;
    do begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready)
        s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata;
    lastResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge ref_clk);
  endtask : axi_read

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    axi_read(a, d);
    check(nm, d & m, exp);
  endtask : rd_chk

  task automatic irq_chk(input logic exp);
    repeat (8) @(posedge ref_clk);
    check("errorIrq", {31'h0, errorIrq}, {31'h0, exp});
  endtask : irq_chk

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
  endtask : do_reset

  task automatic setup(input logic [7:0] c1, input logic [7:0] c3,
                       input logic [1:0] ps, input logic [2:0] ds);
    do_reset();
    axi_write(C1, {24'h0, c1});
    axi_write(C3, {24'h0, c3});
    axi_write(SP, {26'h0, ps, 1'b0, ds});
    bitClk = bit_clocks(ps, ds);
  endtask : setup

  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  // Main sequence
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    lfsr = 16'h3BC6;
    slowAck = 1'b1;
    do_reset();
    rd_chk("control1", C1, 32'hFF, 32'h0);
    rd_chk("control3", C3, 32'hFF, 32'h0);
    rd_chk("speed", SP, 32'hFF, 32'h0);
    rd_chk("status2", S2, 32'h3, 32'h0);
    axi_read(8'h18, rd);
    check("unmapped", {30'h0, lastResp}, {30'h0, RESP_SLVERR});
    axi_write(S2, 32'hFFFFFFFF);
    rd_chk("status2 write", S2, 32'h2, 32'h0);
    slowAck = 1'b0;
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      setup(8'h03, 8'h01, k[1:0], k == 4 ? 3'h3 : 3'h1);
      ch = next_char();
      u_tx.send({1'b0, ch}, 8, 1'b1, bitClk);
      rd_chk("rate data", DT, 32'hFF, {24'h0, ch});
    end
    $display("test rates done");
    fork
      u_tx.send({1'b0, next_char()}, 8, 1'b1, bitClk);
      begin
        repeat (100) @(posedge ref_clk);
        rd_chk("active mid", S2, 32'h1, 32'h1);
      end
    join
    rd_chk("active idle", S2, 32'h1, 32'h0);
    axi_read(DT, rd);
    u_tx.glitch(12);
    repeat (2 * bitClk) @(posedge ref_clk);
    rd_chk("active false", S2, 32'h1, 32'h0);
    rd_chk("no char", S1, 32'h20, 32'h0);
    $display("test active done");
    setup(8'h0B, 8'h01, 2'h0, 3'h1);
    ch = next_char();
    ch[7] = ~^ch[6:0];
    u_tx.send({1'b0, ch}, 8, 1'b1, bitClk);
    irq_chk(1'b1);
    rd_chk("parity flag", S1, 32'h1, 32'h1);
    setup(8'h03, 8'h01, 2'h0, 3'h1);
    u_tx.send({1'b0, 8'h5A}, 8, 1'b0, bitClk);
    irq_chk(1'b0);
    rd_chk("framing flag", S1, 32'h2, 32'h2);
    axi_write(C3, 32'h3);
    irq_chk(1'b1);
    $display("test errors done");
    setup(8'h13, 8'h01, 2'h0, 3'h1);
    u_tx.send(9'h1A5, 9, 1'b1, bitClk);
    rd_chk("ninth bit", C3, 32'h80, 32'h80);
    axi_read(DT, rd);
    for (int b = 0; b < 2; b++) begin
      u_tx.send(9'h000, 9, 1'b0, bitClk);
      irq_chk(1'b0);
      rd_chk("break status1", S1, 32'h22, 32'h22);
      rd_chk("break ninth", C3, 32'h80, 32'h0);
      rd_chk("break flag", S2, 32'h2, 32'h2);
      axi_read(DT, rd);
      rd_chk("break cleared", S2, 32'h2, 32'h0);
    end
    // Line held low over two break frames; only the first may count
    u_tx.glitch(bitClk * 343 / 16);
    repeat (bitClk) @(posedge ref_clk);
    rd_chk("break long", S2, 32'h2, 32'h2);
    axi_read(DT, rd);
    rd_chk("break rearm", S1, 32'h20, 32'h0);
    $display("test break done");
    setup(8'h03, 8'h01, 2'h0, 3'h1);
    for (int i = 0; i < 9; i++) begin
      sent[i] = next_char();
      u_tx.send({1'b0, sent[i]}, 8, 1'b1, bitClk);
    end
    rd_chk("overrun flag", S1, 32'h28, 32'h28);
    irq_chk(1'b0);
    axi_write(C3, 32'h9);
    irq_chk(1'b1);
    for (int i = 0; i < 8; i++)
      rd_chk("fifo data", DT, 32'hFF, {24'h0, sent[i]});
    rd_chk("drained", S1, 32'h28, 32'h0);
    irq_chk(1'b0);
    $display("test overrun done");
    report_and_stop();
  end
endmodule : tb_serial_rx_error_and_baud_select
